// [rtl/ser_ctrl_pkg.sv]
/*
  Constants and types shared by the serial control slave and its synchroniser.
  Assumes a tool that compiles packages before the modules that import them.
*/
package ser_ctrl_pkg;

   // -----------------------------------------------------------------------
   // Device addresses and register space
   // -----------------------------------------------------------------------
   localparam logic [7:0] WRITE_DEVICE_ADDRESS = 8'h8C;
   localparam logic [7:0] READ_DEVICE_ADDRESS  = 8'h8D;
   localparam int         REG_COUNT            = 64;
   localparam int         ADDR_W               = 6;
   localparam int         ADDR_LSB             = 0;
   localparam int         DATA_MSB             = 7;

   // -----------------------------------------------------------------------
   // Counts and values after reset
   // -----------------------------------------------------------------------
   localparam logic [3:0]        BYTE_BITS        = 4'h8;
   localparam logic [3:0]        RESET_BIT_COUNT  = 4'h0;
   localparam logic [7:0]        RESET_REG_VALUE  = 8'h00;
   localparam logic [ADDR_W-1:0] RESET_WORD_ADDR  = 6'h00;
   localparam logic              RESET_OE_N       = 1'b1;
   localparam logic              RESET_SYNC_VALUE = 1'b0;

   // -----------------------------------------------------------------------
   // Link state machine, Gray coded along the write path
   // -----------------------------------------------------------------------
   typedef enum logic [3:0] {
      ST_IDLE     = 4'h0,
      ST_DEV      = 4'h1,
      ST_DEV_ACK  = 4'h3,
      ST_WORD     = 4'h2,
      ST_WORD_ACK = 4'h6,
      ST_WR       = 4'h7,
      ST_WR_ACK   = 4'h5,
      ST_RD       = 4'h4,
      ST_RD_ACK   = 4'hC
   } link_state_t;

endpackage

// [rtl/sync2.sv]
/*
  Two flip-flop synchroniser for one level.
  Assumes the input is a level that stays stable for well over two clock periods.
*/
`timescale 1ns/1ps
module sync2 (
   // Clock and reset
   input  wire logic clk_i,
   input  wire logic rstn_i,
   // Level in and out
   input  wire logic d_i,
   output logic      q_o
);
   import ser_ctrl_pkg::*;

   logic meta_ff;

   // The first stage is read by the second stage only.
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         meta_ff <= RESET_SYNC_VALUE;
         q_o     <= RESET_SYNC_VALUE;
      end else begin
         meta_ff <= d_i;
         q_o     <= meta_ff;
      end
   end

endmodule

// [rtl/ser_ctrl_slave.sv]
/*
  Two-wire serial slave giving read and write access to 64 setting bytes.
  Assumes clk_link_i is a free-running sampling clock several times faster than
  the serial clock, and an open-drain bus resolved outside from the enable.
*/
// Notes on behaviour
// R1: Device address 8Ch is acknowledged and opens a write or a word-address setup.
// R2: Device address 8Dh is acknowledged and is followed by register data to the master.
// R3: The slave holds 64 byte-wide settings selected by the low bits of the word address.
// R4: The master starts a write from an idle bus with the write address and one word address.
// R5: Any number of data bytes after the word address are stored at consecutive locations.
// R6: The word-address counter advances during the acknowledge of every data byte.
// R7: The master turns to reading by a repeated start or a fresh start with the read address.
// R8: Right after acknowledging the read address the slave sends the first byte.
// R9: In a random read the repeated start comes on the first clock after the word-address ack.
// R10: The read byte is the one at the most recently received word address.
// R11: A single-byte read is ended by the master with a not-acknowledge and a stop.
// R12: In sequential reads the slave keeps sending until it sees a not-acknowledge.
// R13: Any number of bytes may be read, the word address incrementing after each one.
// R14: A start plus the read address returns data from the current word address.
// R15: The master keeps the serial clock at or below 400 kHz.
// R16: The word address wraps from the last location back to zero.
`timescale 1ns/1ps
module ser_ctrl_slave (
   // System clock domain
   input  wire logic                                clk_sys_i,
   input  wire logic                                rstn_i,
   // Link sampling clock
   input  wire logic                                clk_link_i,
   // Serial pins
   input  wire logic                                control_serial_clock_pin_i,
   input  wire logic                                control_serial_data_pin_i,
   output logic                                     control_serial_data_pin_o,
   output logic                                     control_serial_data_pin_oe_n_o,
   // Setting updates in the system domain
   output logic                                     setting_write_o,
   output logic [ser_ctrl_pkg::ADDR_W-1:0]          setting_addr_o,
   output logic [ser_ctrl_pkg::DATA_MSB:0]          setting_data_o
);
   import ser_ctrl_pkg::*;

   // -----------------------------------------------------------------------
   // Function
   // -----------------------------------------------------------------------
   function automatic logic [ADDR_W-1:0] address_autoincrement(input logic [ADDR_W-1:0] a);
      address_autoincrement = a + 6'h01; // R16
   endfunction

   // -----------------------------------------------------------------------
   // Link domain reset and pin synchronisers
   // -----------------------------------------------------------------------
   logic rst_link_n, scl_s, sda_s;
   sync2 u_rst_link (.clk_i(clk_link_i), .rstn_i(rstn_i), .d_i(1'b1), .q_o(rst_link_n));
   // Edge detection needs several samples per serial clock phase. R15
   sync2 u_scl (.clk_i(clk_link_i), .rstn_i(rst_link_n),
                .d_i(control_serial_clock_pin_i), .q_o(scl_s));
   sync2 u_sda (.clk_i(clk_link_i), .rstn_i(rst_link_n),
                .d_i(control_serial_data_pin_i), .q_o(sda_s));

   // -----------------------------------------------------------------------
   // Link state
   // -----------------------------------------------------------------------
   link_state_t       state_ff, nxt_state;
   logic [3:0]        cnt_ff, nxt_cnt;
   logic [7:0]        shift_ff, nxt_shift;
   logic [ADDR_W-1:0] addr_ff, nxt_addr;
   logic              oe_n_ff, nxt_oe_n;
   logic              rw_ff, nxt_rw;
   logic              nack_ff, nxt_nack;
   logic              scl_q_ff, sda_q_ff;
   logic              sda_out_ff;
   logic              wr_tgl_ff;
   logic [ADDR_W-1:0] wr_addr_ff;
   logic [7:0]        wr_data_ff;
   logic [7:0]        regs_ff [REG_COUNT];
   logic              reg_we;

   // -----------------------------------------------------------------------
   // Decoding
   // -----------------------------------------------------------------------
   wire       scl_rise_w  = scl_s & ~scl_q_ff;
   wire       scl_fall_w  = ~scl_s & scl_q_ff;
   wire       start_w     = scl_s & scl_q_ff & sda_q_ff & ~sda_s;
   wire       stop_w      = scl_s & scl_q_ff & ~sda_q_ff & sda_s;
   wire       byte_done_w = (cnt_ff == BYTE_BITS);
   wire [7:0] rd_byte_w   = regs_ff[addr_ff];
   wire       dev_match_w = (shift_ff == WRITE_DEVICE_ADDRESS) ||
                            (shift_ff == READ_DEVICE_ADDRESS);

   always_comb begin
      nxt_state = state_ff;
      nxt_cnt   = cnt_ff;
      nxt_shift = shift_ff;
      nxt_addr  = addr_ff;
      nxt_oe_n  = oe_n_ff;
      nxt_rw    = rw_ff;
      nxt_nack  = nack_ff;
      reg_we    = 1'b0;
      if (start_w) begin
         // A start is honoured in any state, so a repeated start turns the direction. R7 R9
         nxt_state = ST_DEV;
         nxt_cnt   = RESET_BIT_COUNT;
         nxt_oe_n  = 1'b1;
      end else if (stop_w) begin
         nxt_state = ST_IDLE; // R4
         nxt_oe_n  = 1'b1;
      end else if (scl_rise_w) begin
         unique case (state_ff)
            ST_DEV, ST_WORD, ST_WR: begin
               nxt_shift = {shift_ff[6:0], sda_s};
               nxt_cnt   = cnt_ff + 4'h1;
            end
            ST_RD: nxt_cnt = cnt_ff + 4'h1;
            ST_RD_ACK: nxt_nack = sda_s; // R12
            default: ;
         endcase
      end else if (scl_fall_w) begin
         unique case (state_ff)
            ST_DEV: if (byte_done_w) begin
               if (dev_match_w) begin
                  nxt_state = ST_DEV_ACK; // R1 R2
                  nxt_oe_n  = 1'b0;
                  nxt_rw    = shift_ff[0];
               end else begin
                  nxt_state = ST_IDLE;
               end
            end
            ST_DEV_ACK: begin
               nxt_cnt = RESET_BIT_COUNT;
               if (rw_ff) begin
                  // Data from the current word address, no address phase. R8 R10 R14
                  nxt_state = ST_RD;
                  nxt_shift = rd_byte_w;
                  nxt_oe_n  = rd_byte_w[7];
               end else begin
                  nxt_state = ST_WORD;
                  nxt_oe_n  = 1'b1;
               end
            end
            ST_WORD: if (byte_done_w) begin
               nxt_addr  = shift_ff[ADDR_W-1:ADDR_LSB]; // R3
               nxt_state = ST_WORD_ACK;
               nxt_oe_n  = 1'b0;
            end
            ST_WORD_ACK, ST_WR_ACK: begin
               nxt_state = ST_WR;
               nxt_oe_n  = 1'b1;
               nxt_cnt   = RESET_BIT_COUNT;
            end
            ST_WR: if (byte_done_w) begin
               reg_we    = 1'b1; // R5
               nxt_addr  = address_autoincrement(addr_ff); // R6
               nxt_state = ST_WR_ACK;
               nxt_oe_n  = 1'b0;
            end
            ST_RD: if (byte_done_w) begin
               nxt_state = ST_RD_ACK;
               nxt_oe_n  = 1'b1;
               nxt_nack  = 1'b1;
               nxt_addr  = address_autoincrement(addr_ff); // R13
            end else begin
               nxt_shift = {shift_ff[6:0], 1'b0};
               nxt_oe_n  = shift_ff[6];
            end
            ST_RD_ACK: begin
               nxt_cnt = RESET_BIT_COUNT;
               if (nack_ff) begin
                  nxt_state = ST_IDLE; // R11 R12
               end else begin
                  nxt_state = ST_RD; // R12
                  nxt_shift = rd_byte_w;
                  nxt_oe_n  = rd_byte_w[7];
               end
            end
            default: nxt_state = ST_IDLE;
         endcase
      end
   end

   // -----------------------------------------------------------------------
   // Link registers
   // -----------------------------------------------------------------------
   always_ff @(posedge clk_link_i or negedge rst_link_n) begin
      if (!rst_link_n) begin
         state_ff   <= ST_IDLE;
         cnt_ff     <= RESET_BIT_COUNT;
         shift_ff   <= RESET_REG_VALUE;
         addr_ff    <= RESET_WORD_ADDR;
         oe_n_ff    <= RESET_OE_N;
         rw_ff      <= 1'b0;
         nack_ff    <= 1'b1;
         scl_q_ff   <= RESET_SYNC_VALUE;
         sda_q_ff   <= RESET_SYNC_VALUE;
         sda_out_ff <= 1'b0;
      end else begin
         state_ff   <= nxt_state;
         cnt_ff     <= nxt_cnt;
         shift_ff   <= nxt_shift;
         addr_ff    <= nxt_addr;
         oe_n_ff    <= nxt_oe_n;
         rw_ff      <= nxt_rw;
         nack_ff    <= nxt_nack;
         scl_q_ff   <= scl_s;
         sda_q_ff   <= sda_s;
         sda_out_ff <= 1'b0;
      end
   end

   // Write data is held until the next write, long after the system side samples it.
   always_ff @(posedge clk_link_i or negedge rst_link_n) begin
      if (!rst_link_n) begin
         for (int i = 0; i < REG_COUNT; i++) regs_ff[i] <= RESET_REG_VALUE;
         wr_tgl_ff  <= 1'b0;
         wr_addr_ff <= RESET_WORD_ADDR;
         wr_data_ff <= RESET_REG_VALUE;
      end else if (reg_we) begin
         regs_ff[addr_ff] <= shift_ff; // R5
         wr_tgl_ff        <= ~wr_tgl_ff;
         wr_addr_ff       <= addr_ff;
         wr_data_ff       <= shift_ff;
      end
   end
   assign control_serial_data_pin_o      = sda_out_ff;
   assign control_serial_data_pin_oe_n_o = oe_n_ff;

   // -----------------------------------------------------------------------
   // System domain crossing
   // -----------------------------------------------------------------------
   logic tgl_s, tgl_q_ff;
   sync2 u_tgl (.clk_i(clk_sys_i), .rstn_i(rstn_i), .d_i(wr_tgl_ff), .q_o(tgl_s));
   wire wr_event_w = tgl_s ^ tgl_q_ff;
   always_ff @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i) begin
         tgl_q_ff        <= 1'b0;
         setting_write_o <= 1'b0;
         setting_addr_o  <= RESET_WORD_ADDR;
         setting_data_o  <= RESET_REG_VALUE;
      end else begin
         tgl_q_ff        <= tgl_s;
         setting_write_o <= wr_event_w;
         if (wr_event_w) begin
            setting_addr_o <= wr_addr_ff;
            setting_data_o <= wr_data_ff;
         end
      end
   end

   // -----------------------------------------------------------------------
   // Assertions
   // -----------------------------------------------------------------------
   wire dev_done_w = scl_fall_w && !start_w && !stop_w && state_ff == ST_DEV && byte_done_w;
   a_dev_ack_match: assert property (@(posedge clk_link_i) disable iff (!rst_link_n) // R1
      dev_done_w && shift_ff == WRITE_DEVICE_ADDRESS |=> state_ff == ST_DEV_ACK && !oe_n_ff && !rw_ff)
      else $error("write device address not acknowledged");
   a_dev_rd_match: assert property (@(posedge clk_link_i) disable iff (!rst_link_n) // R2
      dev_done_w && shift_ff == READ_DEVICE_ADDRESS |=> state_ff == ST_DEV_ACK && !oe_n_ff && rw_ff)
      else $error("read device address not acknowledged");
   a_dev_foreign: assert property (@(posedge clk_link_i) disable iff (!rst_link_n) // R1
      dev_done_w && !dev_match_w |=> state_ff == ST_IDLE && oe_n_ff)
      else $error("foreign address acknowledged");
   a_read_first_bit: assert property (@(posedge clk_link_i) disable iff (!rst_link_n) // R8
      scl_fall_w && !start_w && !stop_w && state_ff == ST_DEV_ACK && rw_ff
      |=> state_ff == ST_RD && oe_n_ff == $past(rd_byte_w[7]))
      else $error("first read bit not driven from current address");
   a_word_load: assert property (@(posedge clk_link_i) disable iff (!rst_link_n) // R3
      scl_fall_w && !start_w && !stop_w && state_ff == ST_WORD && byte_done_w
      |=> addr_ff == $past(shift_ff[ADDR_W-1:0]) && state_ff == ST_WORD_ACK)
      else $error("word address not loaded");
   a_write_store: assert property (@(posedge clk_link_i) disable iff (!rst_link_n) // R5
      reg_we |=> regs_ff[$past(addr_ff)] == $past(shift_ff) && !oe_n_ff)
      else $error("data byte not stored");
   a_wr_incr: assert property (@(posedge clk_link_i) disable iff (!rst_link_n) // R6
      reg_we |=> addr_ff == address_autoincrement($past(addr_ff)))
      else $error("word address not advanced on write");
   a_addr_wrap: assert property (@(posedge clk_link_i) disable iff (!rst_link_n) // R16
      (reg_we || (nxt_state == ST_RD_ACK && state_ff == ST_RD)) && addr_ff == 6'h3F
      |=> addr_ff == 6'h00)
      else $error("word address did not wrap");
   a_rd_nack_end: assert property (@(posedge clk_link_i) disable iff (!rst_link_n) // R12
      scl_fall_w && !start_w && !stop_w && state_ff == ST_RD_ACK && nack_ff
      |=> state_ff == ST_IDLE && oe_n_ff [*2])
      else $error("transmit did not stop after not-acknowledge");
   a_rd_ack_more: assert property (@(posedge clk_link_i) disable iff (!rst_link_n) // R13
      scl_fall_w && !start_w && !stop_w && state_ff == ST_RD_ACK && !nack_ff
      |=> state_ff == ST_RD && shift_ff == $past(rd_byte_w))
      else $error("sequential read did not continue");
   a_stop_release: assert property (@(posedge clk_link_i) disable iff (!rst_link_n) // R4
      stop_w |=> state_ff == ST_IDLE && oe_n_ff)
      else $error("stop did not release the bus");
   a_write_pulse: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
      setting_write_o |=> !setting_write_o)
      else $error("setting write pulse longer than one cycle");
   c_write_byte: cover property (@(posedge clk_link_i) disable iff (!rst_link_n) reg_we);
   c_seq_read: cover property (@(posedge clk_link_i) disable iff (!rst_link_n)
      state_ff == ST_RD_ACK && scl_fall_w && !nack_ff);
   c_read_end: cover property (@(posedge clk_link_i) disable iff (!rst_link_n)
      state_ff == ST_RD_ACK && scl_fall_w && nack_ff);
   c_rep_start: cover property (@(posedge clk_link_i) disable iff (!rst_link_n)
      state_ff == ST_WR && start_w);
endmodule

// [tb/ctrl_bus_master.sv]
/*
  Behavioural two-wire bus master that frames transfers for the control slave.
  Assumes the bench resolves the data wire with a pull-up and clocks clk_i at 100 MHz.
*/
`timescale 1ns/1ps
module ctrl_bus_master (
   // Timing clock
   input  wire logic clk_i,
   // Resolved data wire
   input  wire logic sda_i,
   // Driven lines
   output logic      scl_o,
   output logic      sda_low_o
);
   // ------------------------------------------------------------------
   // Bit timing
   // ------------------------------------------------------------------
   // High phases of 1 us and low phases of 1.5 us give a 2.5 us bit, right at 400 kHz, and
   // leave the slave's synchroniser room on both phases.
   localparam int HALF = 100;
   // Data moves only this long after a clock fall, so that the slave never
   // sees it change while its delayed copy of the clock is still high.
   localparam int GAP  = 50;

   initial begin
      scl_o     = 1'b1;
      sda_low_o = 1'b0;
   end

   task automatic wait_cyc(input int n);
      repeat (n) @(negedge clk_i);
   endtask

   // With the clock low this is the repeated start on the first clock pulse.
   task automatic start_cond();
      sda_low_o = 1'b0;
      wait_cyc(HALF);
      scl_o = 1'b1;
      wait_cyc(HALF);
      sda_low_o = 1'b1;
      wait_cyc(HALF);
      scl_o = 1'b0;
      wait_cyc(GAP);
   endtask

   task automatic stop_cond();
      sda_low_o = 1'b1;
      wait_cyc(HALF);
      scl_o = 1'b1;
      wait_cyc(HALF);
      sda_low_o = 1'b0;
      wait_cyc(HALF);
   endtask

   // Sends b and returns the wire level seen at the end of the high phase.
   task automatic bit_io(input logic b, output logic r);
      sda_low_o = ~b;
      wait_cyc(HALF);
      scl_o = 1'b1;
      wait_cyc(HALF);
      r = sda_i;
      scl_o = 1'b0;
      wait_cyc(GAP);
   endtask

   // A read passes all ones and its own acknowledge as nack_bit.
   task automatic byte_io(input logic [7:0] d, input logic nack_bit,
                          output logic [7:0] q, output logic ack);
      for (int i = 7; i >= 0; i--) begin
         bit_io(d[i], q[i]);
      end
      bit_io(nack_bit, ack);
   endtask
endmodule

// [tb/tb_ser_ctrl_slave.sv]
/*
  Self-checking bench for the serial control slave against a register model.
  Assumes the open-drain data pin resolves with a pull-up on the wire.
*/
`timescale 1ns/1ps
module tb_ser_ctrl_slave;
   import ser_ctrl_pkg::*;

`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin n_mismatch++; \
   $display("MISMATCH t=%0t got=%h exp=%h", $time, (g), (e)); end end

   // ------------------------------------------------------------------
   // Signals and model state
   // ------------------------------------------------------------------
   logic                clk_sys;
   logic                clk_link;
   logic                rstn;
   logic                scl;
   logic                sda_low;
   logic                dout;
   logic                oe_n;
   logic                swr;
   logic [ADDR_W-1:0]   saddr;
   logic [DATA_MSB:0]   sdata;
   wire                 sda_line;
   int                  n_mismatch;
   int                  tests_run;
   int                  addr;
   logic [7:0]          mem [REG_COUNT];
   logic [13:0]         exp_q [$];
   logic [13:0]         exp_w;
   logic [31:0]         seed;
   logic [7:0]          q;
   logic                ack;

   assign sda_line = ~(sda_low | (~oe_n & ~dout));

   ser_ctrl_slave i_ser_ctrl_slave (
      .clk_sys_i                      (clk_sys),
      .rstn_i                         (rstn),
      .clk_link_i                     (clk_link),
      .control_serial_clock_pin_i     (scl),
      .control_serial_data_pin_i      (sda_line),
      .control_serial_data_pin_o      (dout),
      .control_serial_data_pin_oe_n_o (oe_n),
      .setting_write_o                (swr),
      .setting_addr_o                 (saddr),
      .setting_data_o                 (sdata)
   );

   ctrl_bus_master i_ctrl_bus_master (
      .clk_i     (clk_sys),
      .sda_i     (sda_line),
      .scl_o     (scl),
      .sda_low_o (sda_low)
   );

   // ------------------------------------------------------------------
   // Clocks, helpers and monitor
   // ------------------------------------------------------------------
   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end

   // The link clock runs free with an odd offset so its phase never lines up.
   initial begin
      clk_link = 1'b0;
      #37;
      forever #62.5 clk_link = ~clk_link;
   end

   function automatic logic [31:0] xs(input logic [31:0] s);
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      return s ^ (s << 5);
   endfunction

   task automatic complete_run();
      $display("Counts: comparisons %0d mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   // Sampled on the falling edge so the one-cycle pulse is seen settled, once.
   always @(negedge clk_sys) begin
      if (swr === 1'b1) begin
         if (exp_q.size() == 0) begin
            `CHK(swr, 1'b0)
         end else begin
            exp_w = exp_q.pop_front();
            `CHK({saddr, sdata}, exp_w)
         end
      end
   end

   // ------------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------------
   initial begin
      rstn       = 1'b0;
      n_mismatch = 0;
      tests_run  = 0;
      addr       = 0;
      seed       = 32'h0000_07ed;
      foreach (mem[i]) mem[i] = RESET_REG_VALUE;
      repeat (12) @(negedge clk_sys);
      rstn = 1'b1;
      repeat (200) @(negedge clk_sys);
      // A foreign address must be left unanswered.
      i_ctrl_bus_master.start_cond();
      i_ctrl_bus_master.byte_io(8'hA4, 1'b1, q, ack);
      `CHK(ack, 1'b1)
      i_ctrl_bus_master.stop_cond();
      // Page write across the top of the space; upper address bits are dropped.
      i_ctrl_bus_master.start_cond();
      i_ctrl_bus_master.byte_io(WRITE_DEVICE_ADDRESS, 1'b1, q, ack);
      `CHK(ack, 1'b0)
      i_ctrl_bus_master.byte_io(8'hFE, 1'b1, q, ack);
      `CHK(ack, 1'b0)
      addr = 62;
      for (int k = 0; k < 5; k++) begin
         seed = xs(seed);
         mem[addr] = seed[7:0];
         exp_q.push_back({addr[5:0], seed[7:0]});
         i_ctrl_bus_master.byte_io(seed[7:0], 1'b1, q, ack);
         `CHK(ack, 1'b0)
         addr = (addr + 1) % REG_COUNT;
      end
      i_ctrl_bus_master.stop_cond();
      for (int k = 0; k < 2000 && exp_q.size() != 0; k++) @(negedge clk_sys);
      `CHK(exp_q.size(), 0)
      if (exp_q.size() != 0) complete_run();
      // Random read turned into a sequential read over the wrap.
      i_ctrl_bus_master.start_cond();
      i_ctrl_bus_master.byte_io(WRITE_DEVICE_ADDRESS, 1'b1, q, ack);
      `CHK(ack, 1'b0)
      i_ctrl_bus_master.byte_io(8'h3F, 1'b1, q, ack);
      `CHK(ack, 1'b0)
      addr = 63;
      i_ctrl_bus_master.start_cond();
      i_ctrl_bus_master.byte_io(READ_DEVICE_ADDRESS, 1'b1, q, ack);
      `CHK(ack, 1'b0)
      for (int k = 0; k < 3; k++) begin
         i_ctrl_bus_master.byte_io(8'hFF, k == 2, q, ack);
         `CHK(q, mem[addr])
         addr = (addr + 1) % REG_COUNT;
      end
      i_ctrl_bus_master.stop_cond();
      // Current-address read continues where the last read stopped.
      i_ctrl_bus_master.start_cond();
      i_ctrl_bus_master.byte_io(READ_DEVICE_ADDRESS, 1'b1, q, ack);
      `CHK(ack, 1'b0)
      i_ctrl_bus_master.byte_io(8'hFF, 1'b1, q, ack);
      `CHK(q, mem[addr])
      i_ctrl_bus_master.stop_cond();
      `CHK(sda_line, 1'b1)
      complete_run();
   end
endmodule
